// >>> verilog/btc_params.svh
// Constants for the bit-test, compare and call execution unit.
// Assumes inclusion by bare name from the package and the design modules.
`ifndef BTC_PARAMS_SVH
`define BTC_PARAMS_SVH

// ****************************************
// Widths
// ****************************************
`define BTC_DW          16
`define BTC_BITSEL_W    4
`define BTC_LIT8_W      8
`define BTC_TGT_W       23
`define BTC_OP_W        5
`define BTC_FLAG_W      6

// ****************************************
// Flag vector positions
// ****************************************
`define BTC_FLG_C       0
`define BTC_FLG_Z       1
`define BTC_FLG_OVF     2
`define BTC_FLG_N       3
`define BTC_FLG_NIBC    4
`define BTC_FLG_FRAME   5

// ****************************************
// Cycle counts
// ****************************************
`define BTC_CYC_BASE    3'h1
`define BTC_CYC_SKIP1   3'h2
`define BTC_CYC_SKIP2   3'h3
`define BTC_CYC_CALL    3'h4
`define BTC_CYC_BRANCH  3'h5
`define BTC_CYC_SFR     3'h1
`define BTC_CALL_WORDS  2'h2
`define BTC_BASE_WORDS  2'h1

`endif

// >>> verilog/btc_pkg.sv
// Types for the bit-test, compare and call execution unit.
// Assumes btc_params.svh is on the include path.
`include "btc_params.svh"

package btc_pkg;

  // ****************************************
  // Operation codes
  // ****************************************
  typedef enum logic [4:0] {
    BTC_NOP                      = 5'h00,
    BTC_BIT_TEST_SKIP_CLEAR      = 5'h01,
    BTC_BIT_TEST_SKIP_SET        = 5'h02,
    BTC_BIT_TEST_TO_FLAG         = 5'h03,
    BTC_BIT_TEST_THEN_SET        = 5'h04,
    BTC_CALL_DIRECT              = 5'h05,
    BTC_CALL_INDIRECT            = 5'h06,
    BTC_CALL_LONG                = 5'h07,
    BTC_COMPARE_OP               = 5'h08,
    BTC_COMPARE_ZERO_OP          = 5'h09,
    BTC_COMPARE_BORROW_OP        = 5'h0a,
    BTC_COMPARE_SKIP_EQUAL       = 5'h0b,
    BTC_COMPARE_SKIP_GREATER     = 5'h0c,
    BTC_COMPARE_SKIP_LESS        = 5'h0d,
    BTC_COMPARE_SKIP_NOT_EQUAL   = 5'h0e,
    BTC_COMPARE_BRANCH_EQUAL     = 5'h0f,
    BTC_COMPARE_BRANCH_GREATER   = 5'h10,
    BTC_COMPARE_BRANCH_LESS      = 5'h11,
    BTC_COMPARE_BRANCH_NOT_EQUAL = 5'h12
  } btc_op_t;

  typedef enum logic [1:0] {
    BTC_ST_IDLE = 2'b00,
    BTC_ST_BUSY = 2'b01
  } btc_state_t;

endpackage

// >>> verilog/btc_alu.sv
// Subtractor for the compare family: a - b - borrow with all arithmetic flags.
// Assumes operands are stable for the cycle in which they are presented.
`timescale 1ns/10ps
`include "btc_params.svh"

module btc_alu
  import btc_pkg::*;
(
  input  wire logic [`BTC_DW-1:0] i_a,
  input  wire logic [`BTC_DW-1:0] i_b,
  input  wire logic               i_borrow,
  output logic                    o_c,
  output logic                    o_nib_c,
  output logic                    o_n,
  output logic                    o_ovf,
  output logic                    o_z,
  output logic                    o_eq,
  output logic                    o_gt,
  output logic                    o_lt
);

  // Carry means no borrow, as in the subtract-by-complement form
  wire logic [`BTC_DW:0]   sum_w;
  wire logic [4:0]         nib_w;
  wire logic [`BTC_DW-1:0] res_w;

  assign sum_w = {1'b0, i_a} + {1'b0, ~i_b} + {{`BTC_DW{1'b0}}, ~i_borrow};
  assign nib_w = {1'b0, i_a[3:0]} + {1'b0, ~i_b[3:0]} + {4'h0, ~i_borrow};
  assign res_w = sum_w[`BTC_DW-1:0];

  assign o_c  = sum_w[`BTC_DW];
  assign o_nib_c = nib_w[4];
  assign o_n  = res_w[`BTC_DW-1];
  assign o_ovf = (i_a[`BTC_DW-1] ^ i_b[`BTC_DW-1]) & (i_a[`BTC_DW-1] ^ res_w[`BTC_DW-1]);
  assign o_z  = (res_w == {`BTC_DW{1'b0}});
  // Signed relations for the compare-and-skip/branch forms
  assign o_eq = (i_a == i_b);
  assign o_gt = ($signed(i_a) > $signed(i_b));
  assign o_lt = ($signed(i_a) < $signed(i_b));

endmodule

// >>> verilog/btc_exec.sv
// Execution unit for bit-test, compare, compare-skip/branch and call instructions.
// Assumes the fetch stage presents one instruction per i_start pulse and waits
// for o_done; operand fetch and stack push are done by the surrounding core.
`timescale 1ns/10ps
`include "btc_params.svh"

// Operation
// - Skip next when selected bit clear
// - Skip next when selected bit set
// - Bit test copies bit to C, or its complement to Z
// - Test bit to flag, then set it
// - Three call forms, four cycles, frame flag
// - Compare subtracts, updates five arithmetic flags
// - Compare against zero, same five flags
// - Compare subtracts borrow from carry too
// - Skip next when two registers equal
// - Branch when equal, five cycles taken
// - Skip on greater, less or unequal
// - Branch on greater, less or unequal
// - Peripheral register access adds one cycle
module btc_exec
  import btc_pkg::*;
(
  input  wire logic                     i_ref_clk,
  input  wire logic                     i_rst_n,
  input  wire logic                     i_start,
  input  wire logic [`BTC_OP_W-1:0]     i_op,
  input  wire logic [`BTC_DW-1:0]       i_opa,
  input  wire logic [`BTC_DW-1:0]       i_opb,
  input  wire logic [`BTC_BITSEL_W-1:0] i_bit_sel,
  input  wire logic                     i_sel_zero,
  input  wire logic                     i_sfr_access,
  input  wire logic                     i_next_two_words,
  input  wire logic [`BTC_TGT_W-1:0]    i_target,
  input  wire logic                     i_stack_frame_active,
  input  wire logic [`BTC_FLAG_W-1:0]   i_flags,
  output logic                          o_busy,
  output logic                          o_done,
  output logic [`BTC_FLAG_W-1:0]        o_flags,
  output logic [`BTC_DW-1:0]            o_result,
  output logic                          o_write_back,
  output logic                          o_skip,
  output logic                          o_branch,
  output logic                          o_call,
  output logic [`BTC_TGT_W-1:0]         o_target,
  output logic [2:0]                    o_cycles,
  output logic [1:0]                    o_words
);

  // ****************************************
  // Decode
  // ****************************************
  btc_op_t op_w;
  assign op_w = btc_op_t'(i_op);

  wire logic is_skip_clr_w = (op_w == BTC_BIT_TEST_SKIP_CLEAR);
  wire logic is_skip_set_w = (op_w == BTC_BIT_TEST_SKIP_SET);
  wire logic is_bit_flag_w = (op_w == BTC_BIT_TEST_TO_FLAG);
  wire logic is_bit_set_w  = (op_w == BTC_BIT_TEST_THEN_SET);
  wire logic is_call_w     = (op_w == BTC_CALL_DIRECT) | (op_w == BTC_CALL_INDIRECT) |
                             (op_w == BTC_CALL_LONG);
  wire logic is_cmp_w      = (op_w == BTC_COMPARE_OP);
  wire logic is_cmp0_w     = (op_w == BTC_COMPARE_ZERO_OP);
  wire logic is_cmpb_w     = (op_w == BTC_COMPARE_BORROW_OP);
  wire logic is_cskip_w    = (op_w >= BTC_COMPARE_SKIP_EQUAL) &
                             (op_w <= BTC_COMPARE_SKIP_NOT_EQUAL);
  wire logic is_cbr_w      = (op_w >= BTC_COMPARE_BRANCH_EQUAL) &
                             (op_w <= BTC_COMPARE_BRANCH_NOT_EQUAL);
  wire logic is_arith_w    = is_cmp_w | is_cmp0_w | is_cmpb_w;

  // ****************************************
  // Bit test
  // ****************************************
  wire logic sel_bit_w = i_opa[i_bit_sel];
  wire logic [`BTC_DW-1:0] set_mask_w = {{(`BTC_DW-1){1'b0}}, 1'b1} << i_bit_sel;

  // ****************************************
  // Compare
  // ****************************************
  wire logic [`BTC_DW-1:0] alu_b_w = is_cmp0_w ? {`BTC_DW{1'b0}} : i_opb;
  wire logic alu_borrow_w = is_cmpb_w ? ~i_flags[`BTC_FLG_C] : 1'b0;
  logic alu_c, alu_nib_c, alu_n, alu_ovf, alu_z, alu_eq, alu_gt, alu_lt;

  btc_alu i_btc_alu (
    .i_a      (i_opa),
    .i_b      (alu_b_w),
    .i_borrow (alu_borrow_w),
    .o_c      (alu_c),
    .o_nib_c  (alu_nib_c),
    .o_n      (alu_n),
    .o_ovf    (alu_ovf),
    .o_z      (alu_z),
    .o_eq     (alu_eq),
    .o_gt     (alu_gt),
    .o_lt     (alu_lt)
  );

  // Relation for skip and branch forms, decoded from the full operation code
  logic rel_w;
  always_comb begin
    unique case (op_w)
      BTC_COMPARE_SKIP_EQUAL,   BTC_COMPARE_BRANCH_EQUAL:     rel_w = alu_eq;
      BTC_COMPARE_SKIP_GREATER, BTC_COMPARE_BRANCH_GREATER:   rel_w = alu_gt;
      BTC_COMPARE_SKIP_LESS,    BTC_COMPARE_BRANCH_LESS:      rel_w = alu_lt;
      BTC_COMPARE_SKIP_NOT_EQUAL, BTC_COMPARE_BRANCH_NOT_EQUAL: rel_w = ~alu_eq;
      default:                                                rel_w = 1'b0;
    endcase
  end

  wire logic skip_w = (is_skip_clr_w & ~sel_bit_w) |
                      (is_skip_set_w & sel_bit_w) |
                      (is_cskip_w & rel_w);
  wire logic branch_w = is_cbr_w & rel_w;

  // ****************************************
  // Flags and cycle count
  // ****************************************
  logic [`BTC_FLAG_W-1:0] flags_w;
  always_comb begin
    flags_w = i_flags;
    if (is_bit_flag_w | is_bit_set_w) begin
      if (i_sel_zero) begin
        flags_w[`BTC_FLG_Z] = ~sel_bit_w;
      end else begin
        flags_w[`BTC_FLG_C] = sel_bit_w;
      end
    end
    if (is_arith_w) begin
      flags_w[`BTC_FLG_C]  = alu_c;
      flags_w[`BTC_FLG_NIBC] = alu_nib_c;
      flags_w[`BTC_FLG_N]  = alu_n;
      flags_w[`BTC_FLG_OVF] = alu_ovf;
      flags_w[`BTC_FLG_Z]  = alu_z;
    end
    if (is_call_w) begin
      flags_w[`BTC_FLG_FRAME] = i_stack_frame_active;
    end
  end

  logic [2:0] base_cyc_w;
  always_comb begin
    if (is_call_w) begin
      base_cyc_w = `BTC_CYC_CALL;
    end else if (branch_w) begin
      base_cyc_w = `BTC_CYC_BRANCH;
    end else if (skip_w) begin
      base_cyc_w = i_next_two_words ? `BTC_CYC_SKIP2 : `BTC_CYC_SKIP1;
    end else begin
      base_cyc_w = `BTC_CYC_BASE;
    end
  end
  // Only non-core registers pay the extra read cycle; core registers do not
  wire logic [2:0] tot_cyc_w = base_cyc_w + (i_sfr_access ? `BTC_CYC_SFR : 3'h0);

  // ****************************************
  // Sequencer: counts out the instruction's cycles
  // ****************************************
  btc_state_t state_q, state_d;
  logic [2:0] cnt_q, cnt_d;
  wire logic accept_w = i_start & (state_q == BTC_ST_IDLE);

  always_comb begin
    state_d = state_q;
    cnt_d   = cnt_q;
    unique case (state_q)
      BTC_ST_IDLE: begin
        if (accept_w) begin
          state_d = BTC_ST_BUSY;
          cnt_d   = tot_cyc_w - 3'h1;
        end
      end
      BTC_ST_BUSY: begin
        if (cnt_q == 3'h0) begin
          state_d = BTC_ST_IDLE;
        end else begin
          cnt_d = cnt_q - 3'h1;
        end
      end
      default: state_d = BTC_ST_IDLE;
    endcase
  end

  logic [`BTC_FLAG_W-1:0] flags_q;
  logic [`BTC_DW-1:0]     result_q;
  logic                   wb_q, skip_q, branch_q, call_q;
  logic [`BTC_TGT_W-1:0]  target_q;
  logic [2:0]             cycles_q;
  logic [1:0]             words_q;

  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_q <= BTC_ST_IDLE;
      cnt_q   <= 3'h0;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
    end
  end

  // Results are latched at acceptance and held until the next instruction
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      flags_q  <= {`BTC_FLAG_W{1'b0}};
      result_q <= {`BTC_DW{1'b0}};
      wb_q     <= 1'b0;
      skip_q   <= 1'b0;
      branch_q <= 1'b0;
      call_q   <= 1'b0;
      target_q <= {`BTC_TGT_W{1'b0}};
      cycles_q <= 3'h0;
      words_q  <= 2'h0;
    end else if (accept_w) begin
      flags_q  <= flags_w;
      result_q <= i_opa | set_mask_w;
      wb_q     <= is_bit_set_w;
      skip_q   <= skip_w;
      branch_q <= branch_w;
      call_q   <= is_call_w;
      target_q <= i_target;
      cycles_q <= tot_cyc_w;
      words_q  <= (op_w == BTC_CALL_DIRECT) ? `BTC_CALL_WORDS : `BTC_BASE_WORDS;
    end
  end

  assign o_busy       = (state_q == BTC_ST_BUSY);
  assign o_done       = (state_q == BTC_ST_BUSY) & (cnt_q == 3'h0);
  assign o_flags      = flags_q;
  assign o_result     = result_q;
  assign o_write_back = wb_q;
  assign o_skip       = skip_q;
  assign o_branch     = branch_q;
  assign o_call       = call_q;
  assign o_target     = target_q;
  assign o_cycles     = cycles_q;
  assign o_words      = words_q;

  // ****************************************
  // Assertions
  // ****************************************
  logic [2:0] busy_len_q;
  always_ff @(posedge i_ref_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      busy_len_q <= 3'h0;
    end else if (accept_w) begin
      busy_len_q <= 3'h1;
    end else if (o_busy & ~o_done) begin
      busy_len_q <= busy_len_q + 3'h1;
    end
  end

  AST_SKIP_CLEAR: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    accept_w & is_skip_clr_w |=> o_skip == ~$past(sel_bit_w))
    else $error("skip-if-clear decision wrong");
  AST_SKIP_SET: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    accept_w & is_skip_set_w |=> (o_skip == $past(sel_bit_w)) && o_flags == $past(i_flags))
    else $error("skip-if-set decision or flags wrong");
  AST_BIT_TO_FLAG: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    accept_w & is_bit_flag_w & ~i_sel_zero |=> o_flags[`BTC_FLG_C] == $past(sel_bit_w))
    else $error("bit test did not reach carry");
  AST_TEST_THEN_SET: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    accept_w & is_bit_set_w |=> o_write_back && o_result[$past(i_bit_sel)])
    else $error("test-then-set did not set bit");
  AST_CALL_LEN: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    accept_w & is_call_w & ~i_sfr_access |=> (o_busy & ~o_done) [*3] ##1 o_done)
    else $error("call not four cycles");
  AST_CMP_ZERO: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    accept_w & is_cmp_w & (i_opa == i_opb) |=> o_flags[`BTC_FLG_Z] && o_flags[`BTC_FLG_C])
    else $error("equal compare flags wrong");
  AST_CMP0_N: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    accept_w & is_cmp0_w |=> o_flags[`BTC_FLG_N] == $past(i_opa[`BTC_DW-1]))
    else $error("compare-with-zero sign wrong");
  AST_BRANCH_LEN: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    o_done & o_branch |-> busy_len_q == (3'h5 - 3'h1) + (o_cycles - 3'h5) + 3'h1
    && o_cycles >= 3'h5)
    else $error("taken branch not five cycles");
  AST_SKIP_TWO: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    accept_w & skip_w & i_next_two_words & ~i_sfr_access |=> o_cycles == 3'h3)
    else $error("two-word skip not three cycles");
  AST_SFR_EXTRA: assert property (@(posedge i_ref_clk) disable iff (!i_rst_n)
    accept_w & is_arith_w & i_sfr_access |=> o_busy ##1 o_done)
    else $error("peripheral access extra cycle missing");

  COV_SKIP: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_done & o_skip);
  COV_BRANCH: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_done & o_branch);
  COV_CALL: cover property (@(posedge i_ref_clk) disable iff (!i_rst_n) o_done & o_call);

endmodule

// >>> tb/test_btc_exec.sv
// Self-checking bench for the bit-test, compare and call execution unit.
// Assumes btc_params.svh and btc_pkg are compiled first; one instruction per start.
`timescale 1ns/10ps
`include "btc_params.svh"

module test_btc_exec
  import btc_pkg::*;
;
  logic                     ref_clk;
  logic                     rst_n;
  logic                     start;
  btc_op_t                  op;
  logic [`BTC_DW-1:0]       opa;
  logic [`BTC_DW-1:0]       opb;
  logic [`BTC_BITSEL_W-1:0] bit_sel;
  logic                     sel_zero;
  logic                     sfr;
  logic                     two_words;
  logic [`BTC_TGT_W-1:0]    target;
  logic                     sfa_in;
  logic [`BTC_FLAG_W-1:0]   flags_in;
  logic                     busy;
  logic                     done;
  logic [`BTC_FLAG_W-1:0]   flags_out;
  logic [`BTC_DW-1:0]       result;
  logic                     write_back;
  logic                     skip;
  logic                     branch;
  logic                     call;
  logic [`BTC_TGT_W-1:0]    target_out;
  logic [2:0]               cycles;
  logic [1:0]               words;
  int                       fails = 0;
  int                       compares = 0;
  integer                   seed = 66131;

  btc_exec i_btc_exec (
    .i_ref_clk(ref_clk), .i_rst_n(rst_n), .i_start(start), .i_op(op), .i_opa(opa),
    .i_opb(opb), .i_bit_sel(bit_sel), .i_sel_zero(sel_zero), .i_sfr_access(sfr),
    .i_next_two_words(two_words), .i_target(target), .i_stack_frame_active(sfa_in),
    .i_flags(flags_in), .o_busy(busy), .o_done(done), .o_flags(flags_out),
    .o_result(result), .o_write_back(write_back), .o_skip(skip), .o_branch(branch),
    .o_call(call), .o_target(target_out), .o_cycles(cycles), .o_words(words)
  );

  // ****************************************
  // Expectation helpers
  // ****************************************
  // Carry and digit carry read as no borrow
  function automatic logic [5:0] cmpf(input logic [15:0] a, input logic [15:0] b,
                                      input logic br, input logic [5:0] f);
    logic [16:0] d;
    logic [4:0]  h;
    d = {1'h0, a} - {1'h0, b} - {16'h0000, br};
    h = {1'h0, a[3:0]} - {1'h0, b[3:0]} - {4'h0, br};
    cmpf = f;
    cmpf[`BTC_FLG_C] = !d[16];
    cmpf[`BTC_FLG_NIBC] = !h[4];
    cmpf[`BTC_FLG_N] = d[15];
    cmpf[`BTC_FLG_OVF] = (a[15] != b[15]) && (d[15] != a[15]);
    cmpf[`BTC_FLG_Z] = (d[15:0] == 16'h0000);
  endfunction

  // Relation 0 equal, 1 greater, 2 less, 3 unequal; signed
  function automatic logic rel(input logic [1:0] k, input logic [15:0] a, input logic [15:0] b);
    case (k)
      2'h0: rel = (a == b);
      2'h1: rel = ($signed(a) > $signed(b));
      2'h2: rel = ($signed(a) < $signed(b));
      default: rel = (a != b);
    endcase
  endfunction

  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic end_sim();
    $display("Counts: compares=%0d fails=%0d", compares, fails);
    if (fails == 0 && compares > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  // ****************************************
  // Drivers
  // ****************************************
  task automatic randin();
    logic [31:0] r;
    r = $random(seed);
    {opb, opa} = r;
    r = $random(seed);
    {bit_sel, sel_zero, sfr, two_words, sfa_in, flags_in} = r[13:0];
    sfr = sfr & r[20];
    r = $random(seed);
    target = r[22:0];
  endtask

  // Poke keeps start high with another op while busy, which must be ignored
  task automatic run_op(input btc_op_t o, input logic poke);
    logic [5:0]  ef;
    logic [15:0] a0;
    logic [3:0]  b0;
    logic        es;
    logic        eb;
    logic        ec;
    logic        bt;
    logic [2:0]  ecy;
    int          n;
    op = o;
    a0 = opa;
    b0 = bit_sel;
    ef = flags_in;
    es = 1'h0;
    eb = 1'h0;
    ec = 1'h0;
    ecy = 3'h1;
    bt = opa[bit_sel];
    case (o)
      BTC_BIT_TEST_SKIP_CLEAR: es = !bt;
      BTC_BIT_TEST_SKIP_SET: es = bt;
      BTC_BIT_TEST_TO_FLAG, BTC_BIT_TEST_THEN_SET: begin
        if (sel_zero) ef[`BTC_FLG_Z] = !bt;
        else ef[`BTC_FLG_C] = bt;
      end
      BTC_CALL_DIRECT, BTC_CALL_INDIRECT, BTC_CALL_LONG: begin
        ec = 1'h1;
        ecy = 3'h4;
        ef[`BTC_FLG_FRAME] = sfa_in;
      end
      BTC_COMPARE_OP: ef = cmpf(opa, opb, 1'h0, ef);
      BTC_COMPARE_ZERO_OP: ef = cmpf(opa, 16'h0000, 1'h0, ef);
      BTC_COMPARE_BORROW_OP: ef = cmpf(opa, opb, !ef[`BTC_FLG_C], ef);
      default: begin
        if (o inside {[BTC_COMPARE_SKIP_EQUAL:BTC_COMPARE_SKIP_NOT_EQUAL]})
          es = rel(2'(o - 5'h0b), opa, opb);
        if (o inside {[BTC_COMPARE_BRANCH_EQUAL:BTC_COMPARE_BRANCH_NOT_EQUAL]})
          eb = rel(2'(o - 5'h0f), opa, opb);
      end
    endcase
    if (es) ecy = two_words ? 3'h3 : 3'h2;
    if (eb) ecy = 3'h5;
    ecy = ecy + {2'h0, sfr};
    start = 1'h1;
    @(posedge ref_clk);
    #1;
    if (poke) begin
      op = BTC_NOP;
      opa = ~opa;
    end else start = 1'h0;
    n = 1;
    while (done !== 1'h1 && n < 20) begin
      @(posedge ref_clk);
      #1;
      n++;
    end
    start = 1'h0;
    chk(n, ecy);
    chk(cycles, ecy);
    chk(busy, 1'h1);
    chk(flags_out, ef);
    chk({skip, branch, call}, {es, eb, ec});
    chk(words, (o == BTC_CALL_DIRECT) ? 2'h2 : 2'h1);
    chk(write_back, o == BTC_BIT_TEST_THEN_SET);
    if (o == BTC_BIT_TEST_THEN_SET) chk(result, a0 | (16'h0001 << b0));
    if (ec || eb) chk(target_out, target);
    @(posedge ref_clk);
    #1;
    chk(busy, 1'h0);
  endtask

  task automatic dir(input btc_op_t o, input logic [15:0] a, input logic [15:0] b,
                     input logic [3:0] bs, input logic [2:0] m, input logic [5:0] f);
    randin();
    opa = a;
    opb = b;
    bit_sel = bs;
    {sfr, two_words, sel_zero} = m;
    flags_in = f;
    run_op(o, 1'h0);
  endtask

  // ****************************************
  // Clock, watchdog and sequence
  // ****************************************
  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  initial begin
    #100000;
    fails++;
    $display("Watchdog expired before the tests ended");
    end_sim();
  end

  initial begin
    rst_n = 1'h0;
    start = 1'h0;
    op = BTC_NOP;
    randin();
    repeat (12) @(posedge ref_clk);
    #1;
    rst_n = 1'h1;
    @(posedge ref_clk);
    #1;
    chk({busy, done, flags_out, skip, branch, call, cycles, words, write_back}, 32'h0);
    $display("Test reset done");
    dir(BTC_BIT_TEST_SKIP_CLEAR, 16'h7fff, 16'h0000, 4'hf, 3'h2, 6'h3f);
    dir(BTC_BIT_TEST_SKIP_CLEAR, 16'h0001, 16'h0000, 4'h0, 3'h0, 6'h00);
    dir(BTC_BIT_TEST_SKIP_SET, 16'h8000, 16'h0000, 4'hf, 3'h4, 6'h00);
    dir(BTC_BIT_TEST_TO_FLAG, 16'h0001, 16'h0000, 4'h0, 3'h1, 6'h02);
    dir(BTC_BIT_TEST_TO_FLAG, 16'hfffe, 16'h0000, 4'h0, 3'h0, 6'h01);
    dir(BTC_BIT_TEST_THEN_SET, 16'h0000, 16'h0000, 4'hf, 3'h0, 6'h01);
    dir(BTC_BIT_TEST_THEN_SET, 16'h0010, 16'h0000, 4'h4, 3'h5, 6'h00);
    dir(BTC_CALL_DIRECT, 16'h1234, 16'h0000, 4'h0, 3'h0, 6'h00);
    dir(BTC_CALL_INDIRECT, 16'h1234, 16'h0000, 4'h0, 3'h0, 6'h3f);
    dir(BTC_CALL_LONG, 16'h1234, 16'h0000, 4'h0, 3'h4, 6'h00);
    dir(BTC_COMPARE_OP, 16'h8000, 16'h0001, 4'h0, 3'h0, 6'h00);
    dir(BTC_COMPARE_OP, 16'h0010, 16'h0001, 4'h0, 3'h0, 6'h1f);
    dir(BTC_COMPARE_ZERO_OP, 16'h0000, 16'h5a5a, 4'h0, 3'h0, 6'h00);
    dir(BTC_COMPARE_BORROW_OP, 16'h1111, 16'h1111, 4'h0, 3'h0, 6'h02);
    dir(BTC_COMPARE_BORROW_OP, 16'h1111, 16'h1111, 4'h0, 3'h0, 6'h01);
    dir(BTC_COMPARE_SKIP_EQUAL, 16'h00ff, 16'h00ff, 4'h0, 3'h2, 6'h15);
    dir(BTC_COMPARE_BRANCH_EQUAL, 16'h00ff, 16'h00ff, 4'h0, 3'h4, 6'h00);
    dir(BTC_COMPARE_SKIP_GREATER, 16'h0001, 16'h8000, 4'h0, 3'h0, 6'h00);
    dir(BTC_COMPARE_SKIP_LESS, 16'h8000, 16'h0001, 4'h0, 3'h0, 6'h00);
    dir(BTC_COMPARE_SKIP_NOT_EQUAL, 16'h4444, 16'h4444, 4'h0, 3'h0, 6'h00);
    dir(BTC_COMPARE_BRANCH_GREATER, 16'h8000, 16'h0001, 4'h0, 3'h0, 6'h00);
    dir(BTC_COMPARE_BRANCH_LESS, 16'h8000, 16'h0001, 4'h0, 3'h0, 6'h2a);
    dir(BTC_COMPARE_BRANCH_NOT_EQUAL, 16'h0001, 16'h0002, 4'h0, 3'h0, 6'h00);
    $display("Test directed done");
    randin();
    run_op(BTC_CALL_LONG, 1'h1);
    randin();
    run_op(BTC_COMPARE_BRANCH_EQUAL, 1'h1);
    $display("Test refused start done");
    repeat (300) begin
      randin();
      run_op(btc_op_t'(5'h01 + 5'($unsigned($random(seed)) % 18)), 1'h0);
    end
    $display("Test random done");
    end_sim();
  end
endmodule
